// ---- design/mhu_pkg.sv ----
package mhu_pkg;

  // ==========================================================
  // register indices (byte address is four times the index)
  localparam logic [7:0] IDX_PIN22_FLAG = 8'hC0;
  localparam logic [7:0] IDX_PIN2021_FLAG = 8'hC1;
  localparam logic [7:0] IDX_GRP1_FLAG = 8'hC2;
  localparam logic [7:0] IDX_GRP0_FLAG = 8'hC3;
  localparam logic [7:0] IDX_TIMER_FLAGS = 8'hC4;
  localparam logic [7:0] IDX_DIAL_FLAG = 8'hC5;
  localparam logic [7:0] IDX_GRP2_SEL = 8'hC6;
  localparam logic [7:0] IDX_GRP1_SEL = 8'hC7;
  localparam logic [7:0] IDX_GRP0_SEL = 8'hC8;
  localparam logic [7:0] IDX_INPUT_MASKS = 8'hD0;
  localparam logic [7:0] IDX_TIMER_MASKS = 8'hD1;
  localparam logic [7:0] IDX_DIAL_MASK = 8'hD2;
  // status register: bit 0 master enable, bit 1 halted, bit 2 entry busy
  localparam logic [7:0] IDX_CORE_STATUS = 8'hE0;

  // ==========================================================
  // reset values
  localparam logic [3:0] RST_FLAGS = 4'h0;
  localparam logic [3:0] RST_MASKS = 4'h0;
  localparam logic [3:0] RST_SELECT = 4'h0;

  // ==========================================================
  // entry sequence and vectors
  localparam int ENTRY_CYCLES = 12;
  localparam logic [3:0] ENTRY_LAST = 4'(ENTRY_CYCLES - 1);
  localparam logic [3:0] VEC_PAGE = 4'h1;
  localparam logic [3:0] VEC_TIMER = 4'h2;
  localparam logic [3:0] VEC_DIAL = 4'h4;
  localparam logic [3:0] VEC_GRP0 = 4'h6;
  localparam logic [3:0] VEC_GRP1 = 4'h8;
  localparam logic [3:0] VEC_PAIR = 4'hA;
  localparam logic [3:0] VEC_PIN22 = 4'hC;

  // ==========================================================
  // types
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_HALT = 3'b010,
    ST_ENTRY = 3'b100
  } mhu_state_e;

  typedef struct packed {
    logic instrDone;
    logic haltExec;
    logic enableOn;
    logic enableOff;
  } mhu_cpu_s;

  typedef struct packed {
    logic pushReq;
    logic pcLoad;
    logic [3:0] pcPage;
    logic [3:0] pcLow;
  } mhu_entry_s;

endpackage : mhu_pkg

// ---- design/mhu_pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module mhu_pin_sync #(
  parameter int W = 9
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] edgePulse
);

  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;
  logic [W-1:0] stable_r;
  logic [3:0] primed_r;
  logic [W-1:0] agree;

  // change counts once second and third stages agree
  assign agree = ~(s2_r ^ s3_r);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // level is loaded without an edge once the third stage holds real pin data
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stable_r <= '0;
      primed_r <= 4'h0;
      edgePulse <= '0;
    end else begin
      primed_r <= {primed_r[2:0], 1'b1};
      stable_r <= primed_r[3] ? ((stable_r & ~agree) | (s3_r & agree)) : s3_r;
      edgePulse <= primed_r[3] ? (agree & (s3_r ^ stable_r)) : '0;
    end
  end

endmodule : mhu_pin_sync
`default_nettype wire

// ---- design/mhu_prio.sv ----
`timescale 1ns/1ps
`default_nettype none
module mhu_prio (
  input wire logic [5:0] active,
  output logic [3:0] vecLow
);

  // highest vector first: pin22, pair, grp1, grp0, dial, timer
  always_comb begin
    vecLow = mhu_pkg::VEC_TIMER;
    if (active[5]) begin
      vecLow = mhu_pkg::VEC_PIN22;
    end else if (active[4]) begin
      vecLow = mhu_pkg::VEC_PAIR;
    end else if (active[3]) begin
      vecLow = mhu_pkg::VEC_GRP1;
    end else if (active[2]) begin
      vecLow = mhu_pkg::VEC_GRP0;
    end else if (active[1]) begin
      vecLow = mhu_pkg::VEC_DIAL;
    end
  end

endmodule : mhu_prio
`default_nettype wire

// ---- design/mhu_irq_halt.sv ----
// Functional notes
// - accept only with master enable and mask
// - acceptance clears master enable
// - halt stops cpu, clock keeps running
// - interrupt request wakes halted cpu
// - watchdog restarts halted unwoken cpu
// - flag set by source; request needs mask
// - flags set even while masked
// - flags read-only, cleared by read
// - reset clears all pending flags
// - pin edge sets its group flag only if its select bit is set; pin22 always
// - timer falling edges set timer flags
// - dial completion sets flag, read clears
// - masks read/write, zero after reset
// - mask bit placement per register
// - service starts after current instruction
// - vectors in page one, low nibble
// - highest vector wins among pending requests
// - per-pin selection bits, zero after reset
// - unused bits read as zero
`timescale 1ns/1ps
`default_nettype none
module mhu_irq_halt (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic [3:0] inputGroup0Pins,
  input wire logic [3:0] inputGroup1Pins,
  input wire logic [1:0] inputGroup2Pair,
  input wire logic inputSinglePin,
  input wire logic timer1Hz,
  input wire logic timer2Hz,
  input wire logic timer16Hz,
  input wire logic timer32Hz,
  input wire logic dialDone,
  input wire mhu_pkg::mhu_cpu_s cpuIn,
  input wire logic watchdogOn,
  input wire logic watchdogExpire,
  output mhu_pkg::mhu_entry_s entryOut,
  output logic irqReq,
  output logic cpuHalted,
  output logic masterEnable,
  output logic watchdogRestart
);

  // ==========================================================
  // state
  logic [3:0] group0Select_r, group1Select_r;
  logic [1:0] group2Select_r;
  logic [3:0] inputMasks_r, timerMasks_r;
  logic dialMask_r;
  logic pin22Pending_r, pin2021Pending_r, group1Pending_r, group0Pending_r;
  logic [3:0] timerPending_r;
  logic dialPending_r;
  logic [3:0] timerPrev_r;
  logic masterEnable_r;
  mhu_pkg::mhu_state_e state_r;
  logic [3:0] entryCnt_r, vecLatch_r;
  logic busWrite_r;
  logic [7:0] busIdx_r;

  // ==========================================================
  // pin synchronisers and edges
  logic [10:0] pinEdge;
  logic [3:0] timerFall, prioVec;
  logic [5:0] srcActive;
  logic anyRequest;

  // lanes: 3:0 group 0, 7:4 group 1, 9:8 pair, 10 single pin
  mhu_pin_sync #(.W(11)) u_pin_sync (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pinIn({inputSinglePin, inputGroup2Pair, inputGroup1Pins, inputGroup0Pins}),
    .edgePulse(pinEdge)
  );

  logic setGroup0, setGroup1, setPair, setPin22;
  assign setGroup0 = |(pinEdge[3:0] & group0Select_r);
  assign setGroup1 = |(pinEdge[7:4] & group1Select_r);
  assign setPair = |(pinEdge[9:8] & group2Select_r);
  assign setPin22 = pinEdge[10];

  // falling edges of timer rates, order 1, 2, 16, 32 Hz
  assign timerFall = timerPrev_r & ~{timer1Hz, timer2Hz, timer16Hz, timer32Hz};

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerPrev_r <= 4'h0;
    end else begin
      timerPrev_r <= {timer1Hz, timer2Hz, timer16Hz, timer32Hz};
    end
  end

  // ==========================================================
  // bus decode
  logic addrPhase, idxInRange, readNow;
  logic [7:0] reqIdx;

  assign addrPhase = hsel && htrans[1] && hready;
  assign idxInRange = (haddr[31:10] == 22'h00_0000) && (haddr[1:0] == 2'b00);
  assign reqIdx = haddr[9:2];
  assign readNow = addrPhase && !hwrite && idxInRange;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      busWrite_r <= 1'b0;
      busIdx_r <= 8'h00;
    end else if (hready) begin
      busWrite_r <= addrPhase && hwrite && idxInRange;
      busIdx_r <= reqIdx;
    end
  end

  // ==========================================================
  // read clears
  logic clrPin22, clrPair, clrGrp1, clrGrp0, clrTimer, clrDial;
  // a read returns flags then clears them
  assign clrPin22 = readNow && (reqIdx == mhu_pkg::IDX_PIN22_FLAG);
  assign clrPair = readNow && (reqIdx == mhu_pkg::IDX_PIN2021_FLAG);
  assign clrGrp1 = readNow && (reqIdx == mhu_pkg::IDX_GRP1_FLAG);
  assign clrGrp0 = readNow && (reqIdx == mhu_pkg::IDX_GRP0_FLAG);
  assign clrTimer = readNow && (reqIdx == mhu_pkg::IDX_TIMER_FLAGS);
  assign clrDial = readNow && (reqIdx == mhu_pkg::IDX_DIAL_FLAG);

  // ==========================================================
  // pending flags
  // flags set regardless of masks
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin22Pending_r <= 1'b0;
      pin2021Pending_r <= 1'b0;
      group1Pending_r <= 1'b0;
      group0Pending_r <= 1'b0;
    end else begin
      pin22Pending_r <= (pin22Pending_r && !clrPin22) || setPin22;
      pin2021Pending_r <= (pin2021Pending_r && !clrPair) || setPair;
      group1Pending_r <= (group1Pending_r && !clrGrp1) || setGroup1;
      group0Pending_r <= (group0Pending_r && !clrGrp0) || setGroup0;
    end
  end

  // timer flags set by their source
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerPending_r <= mhu_pkg::RST_FLAGS;
      dialPending_r <= 1'b0;
    end else begin
      timerPending_r <= (timerPending_r & {4{!clrTimer}}) | timerFall;
      dialPending_r <= (dialPending_r && !clrDial) || dialDone;
    end
  end

  // ==========================================================
  // masks and selections
  // masks read/write, cleared at reset
  // writes are taken at any time; software keeps them to disabled periods
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inputMasks_r <= mhu_pkg::RST_MASKS;
      timerMasks_r <= mhu_pkg::RST_MASKS;
      dialMask_r <= 1'b0;
      group0Select_r <= mhu_pkg::RST_SELECT;
      group1Select_r <= mhu_pkg::RST_SELECT;
      group2Select_r <= 2'b00;
    end else if (busWrite_r) begin
      unique case (busIdx_r)
        mhu_pkg::IDX_INPUT_MASKS: inputMasks_r <= hwdata[3:0];
        mhu_pkg::IDX_TIMER_MASKS: timerMasks_r <= hwdata[3:0];
        mhu_pkg::IDX_DIAL_MASK: dialMask_r <= hwdata[0];
        mhu_pkg::IDX_GRP0_SEL: group0Select_r <= hwdata[3:0];
        mhu_pkg::IDX_GRP1_SEL: group1Select_r <= hwdata[3:0];
        mhu_pkg::IDX_GRP2_SEL: group2Select_r <= hwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // ==========================================================
  // request and priority
  // masked flags ored into request
  assign srcActive = {
    pin22Pending_r && inputMasks_r[3],
    pin2021Pending_r && inputMasks_r[2],
    group1Pending_r && inputMasks_r[1],
    group0Pending_r && inputMasks_r[0],
    dialPending_r && dialMask_r,
    |(timerPending_r & timerMasks_r)
  };
  assign anyRequest = |srcActive;

  mhu_prio u_prio (
    .active(srcActive),
    .vecLow(prioVec)
  );

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      irqReq <= 1'b0;
    end else begin
      irqReq <= anyRequest;
    end
  end

  // ==========================================================
  // cpu sequencing
  logic accept;
  // accept needs master enable and a masked-in flag
  // only at an instruction boundary or from halt
  assign accept = masterEnable_r && irqReq && anyRequest &&
                  ((state_r == mhu_pkg::ST_RUN && cpuIn.instrDone) ||
                   state_r == mhu_pkg::ST_HALT);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      masterEnable_r <= 1'b0;
    end else if (accept || cpuIn.enableOff) begin
      masterEnable_r <= 1'b0;
    end else if (cpuIn.enableOn) begin
      masterEnable_r <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= mhu_pkg::ST_RUN;
      entryCnt_r <= 4'h0;
      vecLatch_r <= 4'h0;
    end else begin
      unique case (state_r)
        mhu_pkg::ST_RUN: begin
          if (accept) begin
            state_r <= mhu_pkg::ST_ENTRY;
            entryCnt_r <= 4'h0;
            vecLatch_r <= prioVec;
          end else if (cpuIn.haltExec) begin
            state_r <= mhu_pkg::ST_HALT;
          end
        end
        mhu_pkg::ST_HALT: begin
          if (accept) begin
            state_r <= mhu_pkg::ST_ENTRY;
            entryCnt_r <= 4'h0;
            vecLatch_r <= prioVec;
          end else if (irqReq) begin
            state_r <= mhu_pkg::ST_RUN;
          end
        end
        mhu_pkg::ST_ENTRY: begin
          if (entryCnt_r == mhu_pkg::ENTRY_LAST) begin
            state_r <= mhu_pkg::ST_RUN;
          end else begin
            entryCnt_r <= entryCnt_r + 4'h1;
          end
        end
        default: begin
          state_r <= mhu_pkg::ST_RUN;
        end
      endcase
    end
  end

  // page one vector, low nibble from request
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      entryOut <= '0;
    end else begin
      entryOut.pushReq <= (state_r == mhu_pkg::ST_ENTRY) && (entryCnt_r == 4'h0);
      entryOut.pcLoad <= (state_r == mhu_pkg::ST_ENTRY) &&
                         (entryCnt_r == mhu_pkg::ENTRY_LAST);
      entryOut.pcPage <= mhu_pkg::VEC_PAGE;
      entryOut.pcLow <= vecLatch_r;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpuHalted <= 1'b0;
      masterEnable <= 1'b0;
      watchdogRestart <= 1'b0;
    end else begin
      cpuHalted <= (state_r == mhu_pkg::ST_HALT);
      masterEnable <= masterEnable_r;
      watchdogRestart <= (state_r == mhu_pkg::ST_HALT) && watchdogOn && watchdogExpire;
    end
  end

  // ==========================================================
  // read data
  logic [3:0] readVal;
  always_comb begin
    readVal = 4'h0;
    unique case (reqIdx)
      mhu_pkg::IDX_PIN22_FLAG: readVal = {3'b000, pin22Pending_r};
      mhu_pkg::IDX_PIN2021_FLAG: readVal = {3'b000, pin2021Pending_r};
      mhu_pkg::IDX_GRP1_FLAG: readVal = {3'b000, group1Pending_r};
      mhu_pkg::IDX_GRP0_FLAG: readVal = {3'b000, group0Pending_r};
      mhu_pkg::IDX_TIMER_FLAGS: readVal = timerPending_r;
      mhu_pkg::IDX_DIAL_FLAG: readVal = {3'b000, dialPending_r};
      mhu_pkg::IDX_GRP2_SEL: readVal = {2'b00, group2Select_r};
      mhu_pkg::IDX_GRP1_SEL: readVal = group1Select_r;
      mhu_pkg::IDX_GRP0_SEL: readVal = group0Select_r;
      mhu_pkg::IDX_INPUT_MASKS: readVal = inputMasks_r;
      mhu_pkg::IDX_TIMER_MASKS: readVal = timerMasks_r;
      mhu_pkg::IDX_DIAL_MASK: readVal = {3'b000, dialMask_r};
      mhu_pkg::IDX_CORE_STATUS: readVal = {1'b0, state_r == mhu_pkg::ST_ENTRY,
                                          state_r == mhu_pkg::ST_HALT, masterEnable_r};
      default: readVal = 4'h0;
    endcase
    // a write still in its data phase to the same register is forwarded
    if (busWrite_r && (busIdx_r == reqIdx)) begin
      unique case (reqIdx)
        mhu_pkg::IDX_INPUT_MASKS, mhu_pkg::IDX_TIMER_MASKS,
        mhu_pkg::IDX_GRP0_SEL, mhu_pkg::IDX_GRP1_SEL: readVal = hwdata[3:0];
        mhu_pkg::IDX_GRP2_SEL: readVal = {2'b00, hwdata[1:0]};
        mhu_pkg::IDX_DIAL_MASK: readVal = {3'b000, hwdata[0]};
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (hready) begin
        hrdata <= readNow ? {28'h000_0000, readVal} : 32'h0000_0000;
      end
    end
  end

  logic unusedBits;
  assign unusedBits = ^{hsize, hwdata[31:4], htrans[0]};

endmodule : mhu_irq_halt
`default_nettype wire

// ---- dv/mhu_irq_halt_properties.sv ----
`timescale 1ns/1ps
`default_nettype none
module mhu_irq_halt_checker (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [31:0] hrdata,
  input wire mhu_pkg::mhu_cpu_s cpuIn,
  input wire logic watchdogOn,
  input wire logic watchdogExpire,
  input wire mhu_pkg::mhu_entry_s entryOut,
  input wire logic irqReq,
  input wire logic cpuHalted,
  input wire logic masterEnable,
  input wire logic watchdogRestart
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  // ==========================================================
  // interrupt entry
  a_push_then_load: assert property (entryOut.pushReq |-> ##11 entryOut.pcLoad)
    else $error("vector load missing eleven cycles after push");
  a_load_after_push: assert property (entryOut.pcLoad |-> $past(entryOut.pushReq, 11))
    else $error("vector load without push");
  a_vector_page: assert property (entryOut.pcLoad |-> entryOut.pcPage == 4'h1 &&
    entryOut.pcLow inside {4'h2, 4'h4, 4'h6, 4'h8, 4'hA, 4'hC})
    else $error("vector outside page one table");
  a_accept_clears: assert property (masterEnable && irqReq &&
    (cpuIn.instrDone || cpuHalted) |-> ##[1:2] !masterEnable)
    else $error("master enable kept after acceptance");
  a_service_boundary: assert property (entryOut.pushReq |-> $past(cpuIn.instrDone) ||
    $past(cpuHalted) || $past(cpuIn.instrDone, 2) || $past(cpuHalted, 2))
    else $error("entry began inside an instruction");

  // ==========================================================
  // halt, wake and watchdog
  a_halt_enter: assert property (cpuIn.haltExec && !cpuHalted && !irqReq ##1 !irqReq
    |-> ##[0:1] cpuHalted)
    else $error("halt instruction did not stop the core");
  a_wake_on_req: assert property (cpuHalted && irqReq |-> ##[1:2] !cpuHalted)
    else $error("request did not wake the core");
  a_dog_restart: assert property (cpuHalted && watchdogOn && watchdogExpire
    |=> watchdogRestart)
    else $error("watchdog restart missing");
  a_dog_cause: assert property (watchdogRestart |-> $past(watchdogExpire))
    else $error("restart without watchdog expiry");
  a_unused_zero: assert property (hrdata[31:4] == 28'h000_0000)
    else $error("unused read bits not zero");
endmodule : mhu_irq_halt_checker

bind mhu_irq_halt mhu_irq_halt_checker chk (.core_clk, .rst_n, .hrdata, .cpuIn,
  .watchdogOn, .watchdogExpire, .entryOut, .irqReq, .cpuHalted, .masterEnable,
  .watchdogRestart);
`default_nettype wire

// ---- dv/mhu_cpu_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module mhu_cpu_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic cmdEi,
  input wire logic cmdDi,
  input wire logic cmdHalt,
  input wire logic slowMode,
  input wire mhu_pkg::mhu_entry_s entryOut,
  input wire logic cpuHalted,
  output var mhu_pkg::mhu_cpu_s cpuIn
);
  logic [2:0] stepCnt_r;
  logic inEntry_r;

  // ==========================================================
  // entry tracking
  // core waits for vector load
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      inEntry_r <= 1'b0;
    end else if (entryOut.pushReq) begin
      inEntry_r <= 1'b1;
    end else if (entryOut.pcLoad) begin
      inEntry_r <= 1'b0;
    end
  end

  // ==========================================================
  // instruction stream
  // instruction boundaries, enable control
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      stepCnt_r <= 3'h0;
      cpuIn <= '0;
    end else begin
      cpuIn.instrDone <= 1'b0;
      cpuIn.enableOn <= cmdEi;
      cpuIn.enableOff <= cmdDi;
      cpuIn.haltExec <= cmdHalt && !inEntry_r;
      if (cpuHalted || inEntry_r || entryOut.pushReq) begin
        stepCnt_r <= 3'h0;
      end else if (stepCnt_r == (slowMode ? 3'h5 : 3'h1)) begin
        stepCnt_r <= 3'h0;
        cpuIn.instrDone <= 1'b1;
      end else begin
        stepCnt_r <= stepCnt_r + 3'h1;
      end
    end
  end
endmodule : mhu_cpu_model
`default_nettype wire

// ---- dv/mhu_irq_halt_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module mhu_irq_halt_bench;
  logic core_clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, rdPhase;
  logic [31:0] haddr, hwdata, hrdata, rnd;
  logic [1:0] htrans, inputGroup2Pair;
  logic [3:0] inputGroup0Pins, inputGroup1Pins;
  logic inputSinglePin, timer1Hz, timer2Hz, timer16Hz, timer32Hz, dialDone;
  logic watchdogOn, watchdogExpire, irqReq, cpuHalted, masterEnable, watchdogRestart;
  logic cmdEi, cmdDi, cmdHalt, slowMode;
  mhu_pkg::mhu_cpu_s cpuIn;
  mhu_pkg::mhu_entry_s entryOut;
  int errors, checkCount;
  logic [31:0] rdQ[$];
  logic [31:0] vecQ[$];
  logic [7:0] regIdx [6] = '{8'hC6, 8'hC7, 8'hC8, 8'hD0, 8'hD1, 8'hD2};
  logic [3:0] rwMask [6] = '{4'h3, 4'hF, 4'hF, 4'hF, 4'hF, 4'h1};
  logic [7:0] flagIdx [6] = '{8'hC0, 8'hC1, 8'hC2, 8'hC3, 8'hC5, 8'hC4};
  logic [3:0] flagVal [6] = '{4'h1, 4'h1, 4'h1, 4'h1, 4'h1, 4'hF};
  logic [3:0] vecOrd [6] = '{4'hC, 4'hA, 4'h8, 4'h6, 4'h4, 4'h2};

  assign hready = hreadyout;

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  mhu_irq_halt dut (.core_clk, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
    .hwdata, .hready, .hreadyout, .hrdata, .hresp, .inputGroup0Pins, .inputGroup1Pins,
    .inputGroup2Pair, .inputSinglePin, .timer1Hz, .timer2Hz, .timer16Hz, .timer32Hz,
    .dialDone, .cpuIn, .watchdogOn, .watchdogExpire, .entryOut, .irqReq, .cpuHalted,
    .masterEnable, .watchdogRestart);

  mhu_cpu_model cpu (.core_clk, .rst_n, .cmdEi, .cmdDi, .cmdHalt, .slowMode, .entryOut,
    .cpuHalted, .cpuIn);

  // ==========================================================
  // helpers
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp

  task automatic wrap_up;
    if (errors == 0 && checkCount > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : wrap_up

  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    hsel <= 1'b1;
    haddr <= {22'h00_0000, idx, 2'h0};
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
  endtask : bus

  task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
    rdQ.push_back(exp);
    bus(1'b0, idx, 32'h0000_0000);
  endtask : rd

  // one-cycle strobe; sel bits: 4 enable on, 3 enable off, 2 halt, 1 expiry, 0 dial done
  task automatic pulse(input logic [4:0] sel);
    @(posedge core_clk);
    {cmdEi, cmdDi, cmdHalt, watchdogExpire, dialDone} <= sel;
    @(posedge core_clk);
    {cmdEi, cmdDi, cmdHalt, watchdogExpire, dialDone} <= 5'h00;
  endtask : pulse

  // toggles one pin of each pin source, then a falling edge on every timer rate
  task automatic fire;
    rnd = $urandom();
    @(posedge core_clk);
    inputSinglePin <= ~inputSinglePin;
    inputGroup2Pair <= inputGroup2Pair ^ 2'h2;
    inputGroup1Pins <= inputGroup1Pins ^ (4'h1 << rnd[1:0]);
    inputGroup0Pins <= inputGroup0Pins ^ 4'h8;
    {timer1Hz, timer2Hz, timer16Hz, timer32Hz} <= 4'hF;
    dialDone <= 1'b1;
    @(posedge core_clk);
    {timer1Hz, timer2Hz, timer16Hz, timer32Hz} <= 4'h0;
    dialDone <= 1'b0;
    repeat (8) @(posedge core_clk);
  endtask : fire

  // ==========================================================
  // result watcher
  always @(posedge core_clk) rdPhase <= hsel && htrans[1] && !hwrite && hready;

  always @(negedge core_clk) begin
    if (rdPhase) cmp(hrdata, rdQ.pop_front());
    if (rdPhase) cmp(32'({hreadyout, hresp}), 32'h0000_0002);
    if (entryOut.pcLoad) cmp(32'(entryOut.pcLow), vecQ.pop_front());
  end

  initial begin
    repeat (5000) @(posedge core_clk);
    errors++;
    wrap_up();
  end

  // ==========================================================
  // main sequence
  initial begin
    {errors, checkCount, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {inputGroup0Pins, inputGroup1Pins, inputGroup2Pair, inputSinglePin} = '0;
    {timer1Hz, timer2Hz, timer16Hz, timer32Hz, dialDone, watchdogOn, watchdogExpire} = '0;
    {cmdEi, cmdDi, cmdHalt, slowMode} = '0;
    rst_n = 1'b0;
    rnd = $urandom(52);
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    for (int i = 0; i < 6; i++) begin
      rd(flagIdx[i], 32'h0000_0000);
      rd(regIdx[i], 32'h0000_0000);
    end
    rd(8'h3F, 32'h0000_0000);
    for (int i = 0; i < 6; i++) begin
      rnd = $urandom();
      bus(1'b1, regIdx[i], rnd);
      rd(regIdx[i], rnd & 32'(rwMask[i]));
      bus(1'b1, regIdx[i], (i < 3) ? 32'h0000_000F : 32'h0000_0000);
    end
    fire();
    bus(1'b1, 8'hC5, 32'h0000_000F);
    for (int i = 0; i < 6; i++) begin
      rd(flagIdx[i], 32'(flagVal[i]));
      rd(flagIdx[i], 32'h0000_0000);
    end
    pulse(5'h08);
    for (int i = 3; i < 6; i++) bus(1'b1, regIdx[i], 32'h0000_000F);
    fire();
    repeat (20) @(posedge core_clk);
    @(negedge core_clk);
    cmp(32'(irqReq), 32'h0000_0001);
    for (int i = 0; i < 6; i++) begin
      slowMode <= 1'($urandom());
      vecQ.push_back(32'(vecOrd[i]));
      pulse(5'h10);
      do @(negedge core_clk); while (entryOut.pcLoad !== 1'b1);
      cmp(32'(masterEnable), 32'h0000_0000);
      rd(flagIdx[i], 32'(flagVal[i]));
    end
    pulse(5'h04);
    repeat (10) @(posedge core_clk);
    @(negedge core_clk);
    cmp(32'(cpuHalted), 32'h0000_0001);
    @(posedge core_clk) watchdogOn <= 1'b1;
    pulse(5'h02);
    @(negedge core_clk);
    cmp(32'(watchdogRestart), 32'h0000_0001);
    pulse(5'h01);
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    cmp(32'(cpuHalted), 32'h0000_0000);
    rd(8'hC5, 32'h0000_0001);
    repeat (4) @(posedge core_clk);
    wrap_up();
  end
endmodule : mhu_irq_halt_bench
`default_nettype wire
